// file: inc/epc_cfg.svh
// Encoder position counter constants: parameter numbers, fields, reset values
`ifndef EPC_CFG_SVH
`define EPC_CFG_SVH

`define EPC_PAR_IPOS 8'hd1
`define EPC_PAR_ISET 8'hd2
`define EPC_PAR_IMAXDEV 8'hd4
`define EPC_PAR_IANGLE 8'hd7
`define EPC_PAR_EPOS 8'hd8
`define EPC_PAR_ESET 8'hd9
`define EPC_PAR_EMAXDEV 8'hda

`define EPC_ANGLE_W 10
`define EPC_FRAC_W 9
`define EPC_ACC_W 41

`define EPC_ISET_RESET 32'h0000_6400
`define EPC_ESET_RESET 32'h0000_0200
`define EPC_IPRE_MASK 32'hffff_fff0
`define EPC_EPRE_MASK 32'hffff_ffe3

`define EPC_BIT_CLR_NULL 2
`define EPC_BIT_CLR_EACH 3
`define EPC_BIT_NULL_POL 4

`endif

// file: inc/epc_pkg.sv
// Encoder position counter types
package epc_pkg;
  `include "epc_cfg.svh"

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] param;
    logic [31:0] value;
  } epc_cmd_t;

  typedef struct packed {
    logic valid;
    logic error;
    logic [31:0] data;
  } epc_rsp_t;

  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [2:0] lvl;
    logic up;
    logic dn;
    logic null_evt;
  } epc_quad_st_t;

  typedef struct packed {
    logic exceed;
  } epc_dev_st_t;

  typedef struct packed {
    logic [`EPC_ANGLE_W-1:0] s1;
    logic [`EPC_ANGLE_W-1:0] s2;
    logic [`EPC_ANGLE_W-1:0] s3;
    logic [`EPC_ANGLE_W-1:0] ang;
    logic [`EPC_ACC_W-1:0] iacc;
    logic [31:0] iset;
    logic [31:0] imaxdev;
    logic [`EPC_ACC_W-1:0] eacc;
    logic [31:0] eset;
    logic [31:0] emaxdev;
    logic [31:0] mprev;
    logic upd;
    logic stop;
    epc_rsp_t rsp;
  } epc_top_st_t;
endpackage : epc_pkg

// file: rtl/epc_quad.sv
// Quadrature with index interface: pin synchroniser and 4x edge decoder
`timescale 1ns/10ps
module epc_quad
  import epc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic enc_n,
  input wire logic null_pol,
  output logic up,
  output logic dn,
  output logic null_evt
);
  epc_quad_st_t st;
  epc_quad_st_t next_st;
  logic [2:0] lvl_new;

  // A level change counts only once stages two and three agree
  always_comb
  begin
    next_st = st;
    next_st.s1 = {enc_n, enc_b, enc_a};
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < 3; i++)
    begin
      lvl_new[i] = (st.s2[i] == st.s3[i]) ? st.s3[i] : st.lvl[i];
    end
    next_st.lvl = lvl_new;
    // Every edge of A or B counts; a double change is a lost step and is dropped
    next_st.up = ((lvl_new[0] ^ st.lvl[0]) ^ (lvl_new[1] ^ st.lvl[1])) & (lvl_new[0] ^ st.lvl[1]);
    next_st.dn = ((lvl_new[0] ^ st.lvl[0]) ^ (lvl_new[1] ^ st.lvl[1])) & (st.lvl[0] ^ lvl_new[1]);
    next_st.null_evt = (lvl_new[2] != st.lvl[2]) && (lvl_new[2] == null_pol);
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign up = st.up;
  assign dn = st.dn;
  assign null_evt = st.null_evt;

  up_dn_excl_a: assert property (@(posedge mclk) disable iff (!reset_n) !(up && dn))
    else $error("Up and down count in one cycle");
  null_level_a: assert property (@(posedge mclk) disable iff (!reset_n)
    null_evt |-> st.lvl[2] == $past(null_pol))
    else $error("Null event at wrong polarity");
endmodule : epc_quad

// file: rtl/epc_devchk.sv
// Deviation supervisor: absolute position difference against a limit
`timescale 1ns/10ps
module epc_devchk
  import epc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic update,
  input wire logic [31:0] motor_pos,
  input wire logic [31:0] enc_pos,
  input wire logic [31:0] max_dev,
  output logic exceed
);
  epc_dev_st_t st;
  epc_dev_st_t next_st;
  logic signed [32:0] diff;
  logic [32:0] adiff;

  assign diff = $signed({motor_pos[31], motor_pos}) - $signed({enc_pos[31], enc_pos});
  assign adiff = diff[32] ? 33'(-diff) : 33'(diff);

  always_comb
  begin
    next_st = st;
    if (update)
      next_st.exceed = (max_dev != 32'h0) && (adiff > {1'b0, max_dev});
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign exceed = st.exceed;

  zero_disables_a: assert property (@(posedge mclk) disable iff (!reset_n)
    update && max_dev == 32'h0 |=> !exceed)
    else $error("Deviation flagged with supervision off");
endmodule : epc_devchk

// file: rtl/epc_top.sv
// Encoder position counter: internal magnetic and external quadrature encoders
`timescale 1ns/10ps
module epc_top
  import epc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [`EPC_ANGLE_W-1:0] mag_angle,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic enc_n,
  input wire logic [31:0] motor_position,
  input wire logic stop_clear,
  input wire epc_cmd_t cmd,
  output epc_rsp_t rsp,
  output logic motor_stop
);
  epc_top_st_t st;
  epc_top_st_t next_st;
  logic q_up;
  logic q_dn;
  logic q_null;
  logic idev;
  logic edev;
  logic ang_take;
  logic signed [`EPC_ANGLE_W-1:0] idiff;
  logic iwrap;
  logic [31:0] ipre;
  logic [31:0] epre;
  logic signed [43:0] istep;
  logic [`EPC_ACC_W-1:0] estep;
  logic [31:0] ipos;
  logic [31:0] epos;
  logic wr;
  logic rd;

  epc_quad u_quad (
    .mclk(mclk),
    .reset_n(reset_n),
    .enc_a(enc_a),
    .enc_b(enc_b),
    .enc_n(enc_n),
    .null_pol(st.eset[`EPC_BIT_NULL_POL]),
    .up(q_up),
    .dn(q_dn),
    .null_evt(q_null)
  );

  epc_devchk u_idev (
    .mclk(mclk),
    .reset_n(reset_n),
    .update(st.upd),
    .motor_pos(st.mprev),
    .enc_pos(ipos),
    .max_dev(st.imaxdev),
    .exceed(idev)
  );

  epc_devchk u_edev (
    .mclk(mclk),
    .reset_n(reset_n),
    .update(st.upd),
    .motor_pos(st.mprev),
    .enc_pos(epos),
    .max_dev(st.emaxdev),
    .exceed(edev)
  );

  // Positions carry nine fraction bits so sub-unity prescalers do not lose counts
  assign ipos = st.iacc[`EPC_ACC_W-1:`EPC_FRAC_W];
  assign epos = st.eacc[`EPC_ACC_W-1:`EPC_FRAC_W];
  assign ipre = st.iset & `EPC_IPRE_MASK;
  assign epre = st.eset & `EPC_EPRE_MASK;

  // Angle bits sampled as a group; a word only counts once all bits are stable
  assign ang_take = (st.s2 == st.s3) && (st.s3 != st.ang);
  assign idiff = $signed(st.s3 - st.ang);
  assign iwrap = ((idiff > 10'sd0) && (st.s3 < st.ang)) || ((idiff < 10'sd0) && (st.s3 > st.ang));
  assign istep = $signed(idiff) * $signed({1'b0, ipre});
  assign estep = q_up ? {9'h0, epre} : (q_dn ? `EPC_ACC_W'(-{9'h0, epre}) : '0);

  assign wr = cmd.valid && cmd.write;
  assign rd = cmd.valid && !cmd.write;

  always_comb
  begin
    next_st = st;
    next_st.s1 = mag_angle;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.mprev = motor_position;
    next_st.upd = ang_take || q_up || q_dn || (motor_position != st.mprev);
    next_st.rsp = '0;

    if (ang_take)
    begin
      next_st.ang = st.s3;
      if (iwrap && st.iset[`EPC_BIT_CLR_NULL])
        next_st.iacc = '0;
      else
        next_st.iacc = st.iacc + istep[`EPC_ACC_W-1:0];
    end

    if (q_null && st.eset[`EPC_BIT_CLR_NULL])
    begin
      next_st.eacc = '0;
      if (!st.eset[`EPC_BIT_CLR_EACH])
        next_st.eset[`EPC_BIT_CLR_NULL] = 1'b0;
    end
    else
    begin
      next_st.eacc = st.eacc + estep;
    end

    // Stop is sticky so a brief excursion still halts the axis
    if (idev || edev)
      next_st.stop = 1'b1;
    else if (stop_clear)
      next_st.stop = 1'b0;

    // Software writes take priority over same-cycle counting and clearing
    if (wr)
    begin
      case (cmd.param)
        `EPC_PAR_IPOS: next_st.iacc = {cmd.value, 9'h0};
        `EPC_PAR_ISET: next_st.iset = cmd.value;
        `EPC_PAR_IMAXDEV: next_st.imaxdev = cmd.value;
        `EPC_PAR_EPOS: next_st.eacc = {cmd.value, 9'h0};
        `EPC_PAR_ESET: next_st.eset = cmd.value;
        `EPC_PAR_EMAXDEV: next_st.emaxdev = cmd.value;
        default: ;
      endcase
    end

    if (cmd.valid)
    begin
      next_st.rsp.valid = 1'b1;
      case (cmd.param)
        `EPC_PAR_IPOS: next_st.rsp.data = ipos;
        `EPC_PAR_ISET: next_st.rsp.data = st.iset;
        `EPC_PAR_IMAXDEV: next_st.rsp.data = st.imaxdev;
        `EPC_PAR_IANGLE:
        begin
          next_st.rsp.data = {22'h0, st.ang};
          next_st.rsp.error = cmd.write;
        end
        `EPC_PAR_EPOS: next_st.rsp.data = epos;
        `EPC_PAR_ESET: next_st.rsp.data = st.eset;
        `EPC_PAR_EMAXDEV: next_st.rsp.data = st.emaxdev;
        default: next_st.rsp.error = 1'b1;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      st <= '0;
      st.iset <= `EPC_ISET_RESET;
      st.eset <= `EPC_ESET_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign rsp = st.rsp;
  assign motor_stop = st.stop;

  ipos_write_a: assert property (@(posedge mclk) disable iff (!reset_n)
    wr && cmd.param == `EPC_PAR_IPOS |=> ipos == $past(cmd.value))
    else $error("Internal position write lost");
  epos_write_a: assert property (@(posedge mclk) disable iff (!reset_n)
    wr && cmd.param == `EPC_PAR_EPOS |=> epos == $past(cmd.value))
    else $error("External position write lost");
  angle_read_a: assert property (@(posedge mclk) disable iff (!reset_n)
    rd && cmd.param == `EPC_PAR_IANGLE |=> rsp.valid && rsp.data == {22'h0, $past(st.ang)})
    else $error("Angle read wrong");
  izero_cross_a: assert property (@(posedge mclk) disable iff (!reset_n)
    ang_take && iwrap && st.iset[`EPC_BIT_CLR_NULL] && !wr |=> st.iacc == '0)
    else $error("Internal position not cleared at zero angle");
  iscale_a: assert property (@(posedge mclk) disable iff (!reset_n)
    ang_take && !iwrap && !wr |=> st.iacc == $past(st.iacc) + $past(istep[`EPC_ACC_W-1:0]))
    else $error("Internal count not scaled by prescaler");
  escale_a: assert property (@(posedge mclk) disable iff (!reset_n)
    q_up && !q_null && !wr |=> st.eacc == $past(st.eacc) + {9'h0, $past(epre)})
    else $error("External count not scaled by prescaler");
  null_once_a: assert property (@(posedge mclk) disable iff (!reset_n)
    q_null && st.eset[2] && !st.eset[3] && !wr |=> epos == 32'h0 && !st.eset[2])
    else $error("One-shot null clear failed");
  null_each_a: assert property (@(posedge mclk) disable iff (!reset_n)
    q_null && st.eset[2] && st.eset[3] && !wr |=> epos == 32'h0 && st.eset[2])
    else $error("Repeated null clear failed");
  dev_stop_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (idev || edev) |=> motor_stop ##1 (motor_stop || $past(stop_clear)))
    else $error("Deviation did not stop motor");
  unmapped_a: assert property (@(posedge mclk) disable iff (!reset_n)
    cmd.valid && cmd.param == 8'h00 |=> rsp.valid && rsp.error)
    else $error("Unmapped parameter not refused");

  // Command port: one answer per request, one cycle later
  rsp_answer_a: assert property (@(posedge mclk) disable iff (!reset_n)
    cmd.valid |=> rsp.valid)
    else $error("Command not answered");
  rsp_pulse_a: assert property (@(posedge mclk) disable iff (!reset_n)
    !cmd.valid |=> !rsp.valid)
    else $error("Answer without a command");
  refuse_keep_a: assert property (@(posedge mclk) disable iff (!reset_n)
    cmd.valid && cmd.param == 8'h00 |=> st.iset == $past(st.iset) && st.imaxdev == $past(st.imaxdev))
    else $error("Refused command changed settings");
  angle_refuse_a: assert property (@(posedge mclk) disable iff (!reset_n)
    wr && cmd.param == `EPC_PAR_IANGLE |=> rsp.error)
    else $error("Angle write not refused");

  // Settings and limits land exactly as written
  iset_write_a: assert property (@(posedge mclk) disable iff (!reset_n)
    wr && cmd.param == `EPC_PAR_ISET |=> st.iset == $past(cmd.value))
    else $error("Internal settings write lost");
  eset_write_a: assert property (@(posedge mclk) disable iff (!reset_n)
    wr && cmd.param == `EPC_PAR_ESET |=> st.eset == $past(cmd.value))
    else $error("External settings write lost");
  imax_write_a: assert property (@(posedge mclk) disable iff (!reset_n)
    wr && cmd.param == `EPC_PAR_IMAXDEV |=> st.imaxdev == $past(cmd.value))
    else $error("Internal limit write lost");
  emax_write_a: assert property (@(posedge mclk) disable iff (!reset_n)
    wr && cmd.param == `EPC_PAR_EMAXDEV |=> st.emaxdev == $past(cmd.value))
    else $error("External limit write lost");
  eset_keep_a: assert property (@(posedge mclk) disable iff (!reset_n)
    !wr && !q_null |=> st.eset == $past(st.eset))
    else $error("External settings changed on their own");

  // Reads return the value held before the request
  ipos_read_a: assert property (@(posedge mclk) disable iff (!reset_n)
    rd && cmd.param == `EPC_PAR_IPOS |=> rsp.data == $past(ipos))
    else $error("Internal position read wrong");
  epos_read_a: assert property (@(posedge mclk) disable iff (!reset_n)
    rd && cmd.param == `EPC_PAR_EPOS |=> rsp.data == $past(epos))
    else $error("External position read wrong");
  iset_read_a: assert property (@(posedge mclk) disable iff (!reset_n)
    rd && cmd.param == `EPC_PAR_ISET |=> rsp.data == $past(st.iset))
    else $error("Internal settings read wrong");
  eset_read_a: assert property (@(posedge mclk) disable iff (!reset_n)
    rd && cmd.param == `EPC_PAR_ESET |=> rsp.data == $past(st.eset))
    else $error("External settings read wrong");
  imax_read_a: assert property (@(posedge mclk) disable iff (!reset_n)
    rd && cmd.param == `EPC_PAR_IMAXDEV |=> rsp.data == $past(st.imaxdev))
    else $error("Internal limit read wrong");
  emax_read_a: assert property (@(posedge mclk) disable iff (!reset_n)
    rd && cmd.param == `EPC_PAR_EMAXDEV |=> rsp.data == $past(st.emaxdev))
    else $error("External limit read wrong");

  // Counters move only on an accepted step, a position write or a null clear
  angle_take_a: assert property (@(posedge mclk) disable iff (!reset_n)
    ang_take |=> st.ang == $past(st.s3))
    else $error("Accepted angle word not stored");
  angle_hold_a: assert property (@(posedge mclk) disable iff (!reset_n)
    !ang_take |=> st.ang == $past(st.ang))
    else $error("Angle changed without a stable word");
  icount_hold_a: assert property (@(posedge mclk) disable iff (!reset_n)
    !ang_take && !wr |=> st.iacc == $past(st.iacc))
    else $error("Internal count moved without a step");
  escale_down_a: assert property (@(posedge mclk) disable iff (!reset_n)
    q_dn && !q_null && !wr |=> st.eacc == $past(st.eacc) - {9'h0, $past(epre)})
    else $error("External down count not scaled");
  ecount_hold_a: assert property (@(posedge mclk) disable iff (!reset_n)
    !q_up && !q_dn && !q_null && !wr |=> st.eacc == $past(st.eacc))
    else $error("External count moved without an edge");

  // Stop output and supervisor update
  stop_sticky_a: assert property (@(posedge mclk) disable iff (!reset_n)
    motor_stop && !stop_clear |=> motor_stop)
    else $error("Stop dropped without a clear");
  stop_release_a: assert property (@(posedge mclk) disable iff (!reset_n)
    motor_stop && stop_clear && !idev && !edev |=> !motor_stop)
    else $error("Stop not released by clear");
  motor_upd_a: assert property (@(posedge mclk) disable iff (!reset_n)
    motor_position != st.mprev |=> st.upd)
    else $error("Motor move did not trigger a check");

  izero_c: cover property (@(posedge mclk) disable iff (!reset_n) ang_take && iwrap && st.iset[2]);
  ecount_c: cover property (@(posedge mclk) disable iff (!reset_n) q_up ##[1:20] q_dn);
  stop_c: cover property (@(posedge mclk) disable iff (!reset_n) !motor_stop ##1 motor_stop);
  angle_c: cover property (@(posedge mclk) disable iff (!reset_n) rd && cmd.param == `EPC_PAR_IANGLE);
  clear_c: cover property (@(posedge mclk) disable iff (!reset_n) motor_stop && stop_clear && !idev && !edev);
endmodule : epc_top

// file: bench/epc_enc_model.sv
// Encoder partner model: quadrature pins, null pin and magnetic angle word
`timescale 1ns/10ps
`include "epc_cfg.svh"
module epc_enc_model
(
  input wire logic mclk,
  output logic enc_a,
  output logic enc_b,
  output logic enc_n,
  output logic [`EPC_ANGLE_W-1:0] mag_angle
);
  logic [1:0] ph = 2'h0;
  initial
  begin
    enc_a = 1'b0;
    enc_b = 1'b0;
    enc_n = 1'b0;
    mag_angle = 10'h000;
  end
  // Every level held 8 cycles, well past the 3-cycle filter
  task automatic hold();
    repeat (8) @(negedge mclk);
  endtask : hold
  // One edge at a time; A leads B when moving up
  task automatic step(input logic up);
    ph = up ? ph + 2'h1 : ph - 2'h1;
    enc_a = ph[1] ^ ph[0];
    enc_b = ph[1];
    hold();
  endtask : step
  task automatic set_null(input logic lvl);
    enc_n = lvl;
    hold();
  endtask : set_null
  // Angle word wraps at 1024 steps per turn
  task automatic set_angle(input logic [`EPC_ANGLE_W-1:0] v);
    mag_angle = v;
    hold();
  endtask : set_angle
endmodule : epc_enc_model

// file: bench/encoder_position_counter_bench.sv
// Self-checking bench for the encoder position counter
`timescale 1ns/10ps
module encoder_position_counter_bench;
  import epc_pkg::*;
  logic mclk, reset_n, stop_clear, enc_a, enc_b, enc_n, motor_stop;
  logic [`EPC_ANGLE_W-1:0] mag_angle;
  logic [31:0] motor_position, rd;
  epc_cmd_t cmd;
  epc_rsp_t rsp;
  int n_fail = 0;
  int checks_done = 0;
  epc_top uut (
    .mclk(mclk),
    .reset_n(reset_n),
    .mag_angle(mag_angle),
    .enc_a(enc_a),
    .enc_b(enc_b),
    .enc_n(enc_n),
    .motor_position(motor_position),
    .stop_clear(stop_clear),
    .cmd(cmd),
    .rsp(rsp),
    .motor_stop(motor_stop)
  );
  epc_enc_model enc (
    .mclk(mclk),
    .enc_a(enc_a),
    .enc_b(enc_b),
    .enc_n(enc_n),
    .mag_angle(mag_angle)
  );
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic wrap_up();
    $display("Mismatches %0d of %0d checks", n_fail, checks_done);
    if (n_fail == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Request at a falling edge, answer sampled at the next one
  task automatic acc(input logic w, input logic [7:0] par, input logic [31:0] v, input logic err);
    cmd = '{1'b1, w, par, v};
    @(negedge mclk);
    cmd = '0;
    rd = rsp.data;
    chk({30'h0, rsp.valid, rsp.error}, {30'h0, 1'b1, err});
    @(negedge mclk);
  endtask : acc
  task automatic wr(input logic [7:0] par, input logic [31:0] v);
    acc(1'b1, par, v, 1'b0);
  endtask : wr
  task automatic rdchk(input logic [7:0] par, input logic [31:0] exp);
    acc(1'b0, par, 32'h0, 1'b0);
    chk(rd, exp);
  endtask : rdchk
  task automatic t_reset();
    rdchk(`EPC_PAR_ISET, `EPC_ISET_RESET);
    rdchk(`EPC_PAR_ESET, `EPC_ESET_RESET);
    rdchk(`EPC_PAR_IPOS, 32'h0);
    acc(1'b0, 8'h00, 32'h0, 1'b1);
    chk(rd, 32'h0);
    acc(1'b1, `EPC_PAR_IANGLE, 32'h5, 1'b1);
    wr(`EPC_PAR_EPOS, 32'h8000_0000);
    rdchk(`EPC_PAR_EPOS, 32'h8000_0000);
    wr(`EPC_PAR_IPOS, 32'h7fff_ffff);
    rdchk(`EPC_PAR_IPOS, 32'h7fff_ffff);
  endtask : t_reset
  // Binary prescalers only, special bits left clear
  task automatic t_quad();
    logic [31:0] pv [3] = '{32'h40, 32'h400, 32'h8000};
    int ne [3] = '{8, 4, 1};
    for (int k = 0; k < 3; k++)
    begin
      wr(`EPC_PAR_ESET, pv[k]);
      wr(`EPC_PAR_EPOS, 32'h0);
      repeat (ne[k]) enc.step(1'b1);
      rdchk(`EPC_PAR_EPOS, 32'(ne[k] * pv[k] / 512));
    end
    repeat (2) enc.step(1'b0);
    rdchk(`EPC_PAR_EPOS, 32'hffff_ffc0);
  endtask : t_quad
  task automatic t_null();
    enc.set_null(1'b1);
    wr(`EPC_PAR_ESET, 32'h204);
    wr(`EPC_PAR_EPOS, 32'h32);
    enc.set_null(1'b0);
    rdchk(`EPC_PAR_EPOS, 32'h0);
    rdchk(`EPC_PAR_ESET, 32'h200);
    wr(`EPC_PAR_EPOS, 32'h3);
    enc.set_null(1'b1);
    enc.set_null(1'b0);
    rdchk(`EPC_PAR_EPOS, 32'h3);
    wr(`EPC_PAR_ESET, 32'h21c);
    wr(`EPC_PAR_EPOS, 32'h7);
    enc.set_null(1'b1);
    rdchk(`EPC_PAR_EPOS, 32'h0);
    wr(`EPC_PAR_EPOS, 32'h9);
    enc.set_null(1'b0);
    rdchk(`EPC_PAR_EPOS, 32'h9);
    enc.set_null(1'b1);
    rdchk(`EPC_PAR_EPOS, 32'h0);
    rdchk(`EPC_PAR_ESET, 32'h21c);
  endtask : t_null
  task automatic t_angle();
    wr(`EPC_PAR_ISET, 32'h200);
    wr(`EPC_PAR_IPOS, 32'h0);
    enc.set_angle(10'h00a);
    rdchk(`EPC_PAR_IPOS, 32'ha);
    wr(`EPC_PAR_ISET, 32'd25600);
    rdchk(`EPC_PAR_IANGLE, 32'ha);
    enc.set_angle(10'h00b);
    rdchk(`EPC_PAR_IPOS, 32'h3c);
    wr(`EPC_PAR_ISET, 32'h204);
    enc.set_angle(10'h005);
    enc.set_angle(10'h3fc);
    enc.set_angle(10'h3f7);
    rdchk(`EPC_PAR_IPOS, 32'hffff_fffb);
    rdchk(`EPC_PAR_IANGLE, 32'h3f7);
  endtask : t_angle
  task automatic quiet(input logic [31:0] mp);
    motor_position = mp;
    repeat (20) @(negedge mclk);
    chk({31'h0, motor_stop}, 32'h0);
  endtask : quiet
  task automatic wait_stop(input logic [31:0] mp);
    int i;
    motor_position = mp;
    for (i = 0; i < 20 && motor_stop !== 1'b1; i++)
      @(negedge mclk);
    chk({31'h0, motor_stop}, 32'h1);
    if (motor_stop !== 1'b1)
      wrap_up();
  endtask : wait_stop
  task automatic t_dev();
    wr(`EPC_PAR_IPOS, 32'h0);
    wr(`EPC_PAR_EPOS, 32'h0);
    quiet(32'd1000);
    wr(`EPC_PAR_EMAXDEV, 32'h5);
    quiet(32'h5);
    wait_stop(32'h6);
    // Deviation gone but stop holds until cleared
    motor_position = 32'h5;
    repeat (4) @(negedge mclk);
    chk({31'h0, motor_stop}, 32'h1);
    stop_clear = 1'b1;
    @(negedge mclk);
    stop_clear = 1'b0;
    wr(`EPC_PAR_EMAXDEV, 32'h0);
    wr(`EPC_PAR_IMAXDEV, 32'h5);
    quiet(32'hffff_fffb);
    wait_stop(32'hffff_fffa);
  endtask : t_dev
  // Mid-run reset; positions not checked, pins may sit anywhere
  task automatic t_rerun();
    reset_n = 1'b0;
    repeat (2) @(negedge mclk);
    reset_n = 1'b1;
    chk({31'h0, motor_stop}, 32'h0);
    @(negedge mclk);
    rdchk(`EPC_PAR_IMAXDEV, 32'h0);
    rdchk(`EPC_PAR_ESET, `EPC_ESET_RESET);
  endtask : t_rerun
  initial
  begin
    reset_n = 1'b0;
    stop_clear = 1'b0;
    motor_position = 32'h0;
    cmd = '0;
    repeat (6) @(negedge mclk);
    reset_n = 1'b1;
    @(negedge mclk);
    t_reset();
    t_quad();
    t_null();
    t_angle();
    t_dev();
    t_rerun();
    wrap_up();
  end
endmodule : encoder_position_counter_bench
